/* rtl/srafe_pkg.sv */
// Shared constants and types of the serial register address front end
package srafe_pkg;
    // Clock and link timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int LINK_PERIOD_NS = 160;
    localparam int QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // Target address byte
    localparam logic [6:0] TGT_BASE = 7'h48;
    localparam int ADDR_DIR_BIT = 0;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    // Register address byte fields
    localparam int SUB_RW_BIT = 7;
    localparam int SUB_REG_MSB = 6;
    localparam int SUB_REG_LSB = 3;
    localparam int SUB_CH_MSB = 2;
    localparam int SUB_CH_LSB = 1;
    localparam logic [1:0] CH_ALLOWED = 2'h0;
    localparam logic SUB_UNUSED = 1'h0;
    // Bit counter marks
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_POST = 4'h9;
    // Device bus state
    typedef enum logic [2:0] {
        D_IDLE, D_ADDR, D_SUB, D_WR, D_RD, D_IGN
    } srafe_dst_t;
    // Host sequencer state and byte stage
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} srafe_hst_t;
    typedef enum logic [2:0] {
        G_ADDRW, G_SUB, G_ADDRR, G_WDATA, G_RDATA
    } srafe_stage_t;
endpackage : srafe_pkg

/* rtl/srafe_if.sv */
// Link between host and device: two-wire and four-wire serial pins
`timescale 1ns/1ps
`default_nettype none
interface srafe_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    // Open-drain data line: low when any enabled driver pulls low
    assign sda = ((!host_sda_oe_n && !host_sda_o) ||
                  (!dev_sda_oe_n && !dev_sda_o)) ? 1'h0 : 1'h1;
    modport host (
        output scl, host_sda_o, host_sda_oe_n, cs_n, sclk, mosi,
        input sda, miso
    );
    modport dev (
        output dev_sda_o, dev_sda_oe_n, miso,
        input scl, sda, cs_n, sclk, mosi
    );
endinterface : srafe_if
`default_nettype wire

/* rtl/srafe_device.sv */
// Device end: target bus port and register address decoder
// Function
// - Register address byte follows target address
// - Address byte eight bits, acknowledged
// - Bits 6:3 select internal register
// - Host sends channel bits as zero
// - Two-wire: bits 7 and 0 ignored
// - Write: start, address, register, data, stop
// - Read: write header, repeated start, read
// - Device shifts bytes; host acks non-last
// - Host nacks last byte, then stop
// - Four-wire: bit 7 one means read
// - Address byte: seven bits plus direction
// - Straps give addresses 0x90 to 0xae
`timescale 1ns/1ps
`default_nettype none
module srafe_device (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Serial link
    srafe_if.dev link,
    // Straps and interface choice
    input wire logic [1:0] target_addr_pin_high,
    input wire logic [1:0] target_addr_pin_low,
    input wire logic use_spi,
    // Register side
    output logic [3:0] reg_sel_q,
    output logic [1:0] chan_sel_q,
    output logic acc_read_q,
    output logic wr_stb_q,
    output logic [7:0] wr_data_q,
    output logic rd_stb_q,
    input wire logic [7:0] rd_data
);
    import srafe_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic [1:0] e_q;
    wire [9:0] raw = {target_addr_pin_high, target_addr_pin_low, use_spi,
                      link.cs_n, link.sclk, link.mosi, link.scl, link.sda};
    wire sda_s = s2_q[0];
    wire scl_s = s2_q[1];
    wire mosi_s = s2_q[2];
    wire sclk_s = s2_q[3];
    wire cs_n_s = s2_q[4];
    wire spi_s = s2_q[5];
    wire [3:0] tgt_idx = s2_q[9:6];

    // Two flops per pin, then one more for edge finding
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle pin levels, so no false edge follows reset
            s1_q <= 10'h3f3;
            s2_q <= 10'h3f3;
            e_q <= 2'h1;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            e_q <= {s2_q[3], s2_q[1]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge and condition decode
    wire scl_rise = scl_s & ~e_q[0];
    wire scl_fall = ~scl_s & e_q[0];
    wire sclk_rise = sclk_s & ~e_q[1];
    wire sclk_fall = ~sclk_s & e_q[1];
    wire sda_prev = s2_q[0];
    logic sda_d1_q;
    wire start_c = scl_s & e_q[0] & sda_d1_q & ~sda_s;
    wire stop_c = scl_s & e_q[0] & ~sda_d1_q & sda_s;

    // Delayed data line for start and stop detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sda_d1_q <= 1'h1;
        end else begin
            sda_d1_q <= sda_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Byte assembly and address match
    srafe_dst_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic hdr_q;
    logic sda_oe_n_q;
    logic miso_q;
    wire [7:0] i2c_nx = {sh_q[6:0], sda_s};
    wire [7:0] spi_nx = {sh_q[6:0], mosi_s};
    wire [6:0] own_addr = TGT_BASE + {3'h0, tgt_idx};
    wire addr_hit = (sh_q[7:1] == own_addr);
    wire rd_bit_fall = scl_fall & (st_q == D_RD) &
                       ((cnt_q == CNT_POST) ||
                        ((cnt_q != 4'h0) && (cnt_q < CNT_ACK)));
    wire spi_fall = sclk_fall & ~cs_n_s;

    assign link.dev_sda_o = 1'h0;
    assign link.dev_sda_oe_n = sda_oe_n_q;
    assign link.miso = miso_q;

    ////////////////////////////////////////////////////////////////////
    // Read data shifter: load on read strobe, shift per output bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= 8'h00;
            miso_q <= 1'h0;
        end else if (rd_stb_q) begin
            tx_q <= rd_data;
        end else if (rd_bit_fall | (spi_s & spi_fall)) begin
            tx_q <= {tx_q[6:0], 1'h0};
            miso_q <= tx_q[7];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Protocol engine for both bus types
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= D_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            hdr_q <= 1'h1;
            sda_oe_n_q <= 1'h1;
            reg_sel_q <= 4'h0;
            chan_sel_q <= 2'h0;
            acc_read_q <= 1'h0;
            wr_stb_q <= 1'h0;
            wr_data_q <= 8'h00;
            rd_stb_q <= 1'h0;
        end else begin
            wr_stb_q <= 1'h0;
            rd_stb_q <= 1'h0;
            if (spi_s) begin
                st_q <= D_IDLE;
                sda_oe_n_q <= 1'h1;
                if (cs_n_s) begin
                    cnt_q <= 4'h0;
                    hdr_q <= 1'h1;
                end else if (sclk_rise) begin
                    sh_q <= spi_nx;
                    cnt_q <= (cnt_q == CNT_LAST) ? 4'h0 : cnt_q + 4'h1;
                    if (cnt_q == CNT_LAST) begin
                        hdr_q <= 1'h0;
                        if (hdr_q) begin
                            reg_sel_q <= spi_nx[SUB_REG_MSB:SUB_REG_LSB];
                            chan_sel_q <= spi_nx[SUB_CH_MSB:SUB_CH_LSB];
                            acc_read_q <= spi_nx[SUB_RW_BIT];
                            rd_stb_q <= spi_nx[SUB_RW_BIT];
                        end else if (acc_read_q) begin
                            rd_stb_q <= 1'h1;
                        end else begin
                            wr_stb_q <= 1'h1;
                            wr_data_q <= spi_nx;
                        end
                    end
                end
            end else if (start_c) begin
                st_q <= D_ADDR;
                cnt_q <= 4'h0;
                sda_oe_n_q <= 1'h1;
            end else if (stop_c) begin
                st_q <= D_IDLE;
                sda_oe_n_q <= 1'h1;
            end else if (scl_rise) begin
                if (cnt_q == CNT_ACK) begin
                    cnt_q <= CNT_POST;
                    // next byte only after host ack
                    if (st_q == D_RD) begin
                        if (sda_s) begin
                            st_q <= D_IGN;
                        end else begin
                            rd_stb_q <= 1'h1;
                        end
                    end
                end else if (cnt_q < CNT_ACK) begin
                    sh_q <= i2c_nx;
                    cnt_q <= cnt_q + 4'h1;
                end
            end else if (scl_fall) begin
                if (cnt_q == CNT_ACK) begin
                    sda_oe_n_q <= 1'h1;
                    case (st_q)
                        D_ADDR: begin
                            if (addr_hit) begin
                                sda_oe_n_q <= 1'h0;
                                acc_read_q <= sh_q[ADDR_DIR_BIT];
                                st_q <= (sh_q[ADDR_DIR_BIT] == DIR_READ) ?
                                        D_RD : D_SUB;
                            end else begin
                                st_q <= D_IGN;
                            end
                        end
                        D_SUB: begin
                            sda_oe_n_q <= 1'h0;
                            reg_sel_q <= sh_q[SUB_REG_MSB:SUB_REG_LSB];
                            chan_sel_q <= sh_q[SUB_CH_MSB:SUB_CH_LSB];
                            st_q <= D_WR;
                        end
                        D_WR: begin
                            // each byte to the same register
                            sda_oe_n_q <= 1'h0;
                            wr_stb_q <= 1'h1;
                            wr_data_q <= sh_q;
                        end
                        default: sda_oe_n_q <= 1'h1;
                    endcase
                end else if (cnt_q == CNT_POST) begin
                    cnt_q <= 4'h0;
                    sda_oe_n_q <= (st_q == D_RD) ? tx_q[7] : 1'h1;
                end else if (rd_bit_fall) begin
                    sda_oe_n_q <= tx_q[7];
                end
            end
        end
    end
endmodule : srafe_device
`default_nettype wire

/* rtl/srafe_host.sv */
// Host end: bus controller that sends register accesses to the device
`timescale 1ns/1ps
`default_nettype none
module srafe_host #(
    parameter int QTR_CYC = srafe_pkg::QTR_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Serial link
    srafe_if.host link,
    // Request
    input wire logic req,
    input wire logic req_spi,
    input wire logic req_read,
    input wire logic [3:0] req_tgt,
    input wire logic [3:0] req_reg,
    input wire logic [7:0] req_len,
    // Write data
    input wire logic [7:0] wr_data,
    output logic wr_take_q,
    // Answers
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    output logic busy_q,
    output logic done_q,
    output logic nack_q
);
    import srafe_pkg::*;

    // Quarter period must be at least one clock
    if (QTR_CYC < 1) begin : g_chk
        $error("QTR_CYC must be at least one");
    end

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers for data line and slave output
    logic [1:0] s1_q;
    logic [1:0] s2_q;

    // Two flops before any use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
        end else begin
            s1_q <= {link.miso, link.sda};
            s2_q <= s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State and pin registers
    srafe_hst_t st_q;
    srafe_stage_t stg_q;
    logic [15:0] div_q;
    logic [1:0] q_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] left_q;
    logic spi_q;
    logic rd_q;
    logic [3:0] tgt_q;
    logic [3:0] reg_q;
    logic scl_q;
    logic sda_oe_n_q;
    logic sclk_q;
    logic cs_n_q;
    logic mosi_q;

    assign link.scl = scl_q;
    assign link.host_sda_o = 1'h0;
    assign link.host_sda_oe_n = sda_oe_n_q;
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = mosi_q;

    ////////////////////////////////////////////////////////////////////
    // Byte building and sequencing decode
    // target address byte with direction
    wire [6:0] tgt_addr = TGT_BASE + {3'h0, tgt_q};
    wire [6:0] req_addr = TGT_BASE + {3'h0, req_tgt};
    wire [7:0] addr_w = {req_addr, DIR_WRITE};
    wire [7:0] addr_r = {tgt_addr, DIR_READ};
    // register address byte, channel bits zero
    wire [7:0] sub_q = {spi_q & rd_q, reg_q, CH_ALLOWED, SUB_UNUSED};
    wire [7:0] sub_req = {req_read, req_reg, CH_ALLOWED, SUB_UNUSED};
    wire tick = (st_q != H_IDLE) &&
                (div_q == 16'(QTR_CYC - 1));
    wire in_bit = spi_q ? s2_q[1] : s2_q[0];
    wire byte_end = spi_q ? (bit_q == CNT_LAST) : (bit_q == CNT_ACK);
    wire [7:0] sh_in = {sh_q[6:0], in_bit};
    wire [7:0] byte_in = spi_q ? sh_in : sh_q;
    wire last_rd = (left_q == 8'h01);
    wire is_rdat = (stg_q == G_RDATA);

    ////////////////////////////////////////////////////////////////////
    // Quarter-period divider, runs only while busy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 16'h0000;
        end else if (st_q == H_IDLE || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer: each step takes four quarters of a link period
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= H_IDLE;
            stg_q <= G_ADDRW;
            q_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            left_q <= 8'h01;
            spi_q <= 1'h0;
            rd_q <= 1'h0;
            tgt_q <= 4'h0;
            reg_q <= 4'h0;
            scl_q <= 1'h1;
            sda_oe_n_q <= 1'h1;
            sclk_q <= 1'h0;
            cs_n_q <= 1'h1;
            mosi_q <= 1'h0;
            wr_take_q <= 1'h0;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'h0;
            busy_q <= 1'h0;
            done_q <= 1'h0;
            nack_q <= 1'h0;
        end else begin
            wr_take_q <= 1'h0;
            rd_valid_q <= 1'h0;
            done_q <= 1'h0;
            case (st_q)
                H_IDLE: begin
                    if (req) begin
                        st_q <= H_START;
                        q_q <= 2'h0;
                        busy_q <= 1'h1;
                        nack_q <= 1'h0;
                        spi_q <= req_spi;
                        rd_q <= req_read;
                        tgt_q <= req_tgt;
                        reg_q <= req_reg;
                        left_q <= (req_len == 8'h00) ? 8'h01 : req_len;
                        // first byte after start or select
                        stg_q <= req_spi ? G_SUB : G_ADDRW;
                        sh_q <= req_spi ? sub_req : addr_w;
                    end
                end
                H_START: begin
                    if (tick) begin
                        q_q <= q_q + 2'h1;
                        case (q_q)
                            2'h0: begin
                                if (spi_q) begin
                                    cs_n_q <= 1'h0;
                                end else begin
                                    sda_oe_n_q <= 1'h1;
                                end
                            end
                            2'h1: scl_q <= 1'h1;
                            2'h2: sda_oe_n_q <= spi_q;
                            default: begin
                                scl_q <= spi_q;
                                st_q <= H_BIT;
                                bit_q <= 4'h0;
                            end
                        endcase
                    end
                end
                H_BIT: begin
                    if (tick) begin
                        q_q <= q_q + 2'h1;
                        case (q_q)
                            2'h0: begin
                                if (spi_q) begin
                                    mosi_q <= sh_q[7];
                                end else if (bit_q < CNT_ACK) begin
                                    sda_oe_n_q <= is_rdat | sh_q[7];
                                end else begin
                                    // ack every read byte but the last
                                    sda_oe_n_q <= ~(is_rdat & ~last_rd);
                                end
                            end
                            2'h1: begin
                                scl_q <= scl_q | ~spi_q;
                                sclk_q <= spi_q;
                            end
                            2'h2: begin
                                bit_q <= bit_q;
                            end
                            default: begin
                                scl_q <= spi_q;
                                sclk_q <= 1'h0;
                                bit_q <= bit_q + 4'h1;
                                if (bit_q < CNT_ACK) begin
                                    sh_q <= sh_in;
                                end
                                if (byte_end) begin
                                    bit_q <= 4'h0;
                                    if (is_rdat) begin
                                        rd_data_q <= byte_in;
                                        rd_valid_q <= 1'h1;
                                        left_q <= left_q - 8'h01;
                                        if (last_rd) begin
                                            st_q <= H_STOP;
                                        end
                                    end else if (!spi_q && in_bit) begin
                                        nack_q <= 1'h1;
                                        st_q <= H_STOP;
                                    end else begin
                                        case (stg_q)
                                            G_ADDRW: begin
                                                stg_q <= G_SUB;
                                                sh_q <= sub_q;
                                            end
                                            G_SUB: begin
                                                if (rd_q && spi_q) begin
                                                    stg_q <= G_RDATA;
                                                end else if (rd_q) begin
                                                    stg_q <= G_ADDRR;
                                                    sh_q <= addr_r;
                                                    st_q <= H_START;
                                                end else begin
                                                    stg_q <= G_WDATA;
                                                    sh_q <= wr_data;
                                                    wr_take_q <= 1'h1;
                                                end
                                            end
                                            G_ADDRR: stg_q <= G_RDATA;
                                            default: begin
                                                left_q <= left_q - 8'h01;
                                                if (last_rd) begin
                                                    st_q <= H_STOP;
                                                end else begin
                                                    sh_q <= wr_data;
                                                    wr_take_q <= 1'h1;
                                                end
                                            end
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                end
                H_STOP: begin
                    if (tick) begin
                        q_q <= q_q + 2'h1;
                        case (q_q)
                            2'h0: begin
                                if (spi_q) begin
                                    cs_n_q <= 1'h1;
                                end else begin
                                    sda_oe_n_q <= 1'h0;
                                end
                            end
                            2'h1: scl_q <= 1'h1;
                            2'h2: sda_oe_n_q <= 1'h1;
                            default: begin
                                st_q <= H_IDLE;
                                busy_q <= 1'h0;
                                done_q <= 1'h1;
                            end
                        endcase
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule : srafe_host
`default_nettype wire

/* verif/srafe_properties.sv */
// Checker: pin timing on the two-wire and four-wire link
`timescale 1ns/1ps
`default_nettype none
module srafe_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link pins
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic miso
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////
    // Two-wire start, stop and clock shape
    sequence start_seen; scl && $fell(sda); endsequence
    sequence stop_seen; scl && $rose(sda); endsequence
    a_start_clock_low: assert property (start_seen |-> ##[1:4] !scl)
        else $error("no clock low after start");
    a_stop_bus_idle: assert property (stop_seen |=> scl [*2])
        else $error("clock moved after stop");
    a_scl_high_len: assert property ($rose(scl) |-> scl [*4])
        else $error("short clock high");
    a_dev_sda_move: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device data moved in clock high");
    ////////////////////
    // Four-wire framing and clocking
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("serial clock out of frame");
    a_scl_quiet: assert property (!cs_n |-> scl)
        else $error("two-wire clock in frame");
    a_sclk_pulse: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("bad serial clock pulse");
    a_miso_shift: assert property ($changed(miso) |-> !sclk)
        else $error("read data moved in clock high");
    a_frame_min: assert property ($fell(cs_n) |-> !cs_n [*8])
        else $error("frame too short");
endmodule : srafe_properties
`default_nettype wire

/* verif/serial_register_address_front_end_tb.sv */
// Bench: host and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module serial_register_address_front_end_tb;
    // Stimulus, answers and tallies
    logic mclk = 1'h0, rst_n = 1'h0, req = 1'h0, req_spi = 1'h0;
    logic req_read = 1'h0, use_spi = 1'h0, acc_read_q, wr_stb_q;
    logic wr_take_q, rd_valid_q, done_q, nack_q, busy_q, rd_stb_q;
    logic [1:0] chan_sel_q;
    logic [3:0] req_tgt = 4'h0, req_reg = 4'h0, reg_sel_q, strap = 4'h5;
    logic [7:0] req_len = 8'h1, wr_data = 8'h10, last_wr, rd_data_q, wr_data_q;
    int failures = 0, comparisons = 0, nwr = 0, nrd = 0, nrs = 0;
    // Register contents: a tag plus the select
    wire logic [7:0] rd_data = {4'ha, reg_sel_q};
    always #10 mclk = ~mclk;
    ////////////////////
    srafe_if u_srafe_if ();
    srafe_host u_srafe_host (.mclk, .rst_n, .link(u_srafe_if), .req,
        .req_spi, .req_read, .req_tgt, .req_reg, .req_len, .wr_data,
        .wr_take_q, .rd_data_q, .rd_valid_q, .busy_q, .done_q, .nack_q);
    srafe_device u_srafe_device (.mclk, .rst_n, .link(u_srafe_if),
        .target_addr_pin_high(strap[3:2]),
        .target_addr_pin_low(strap[1:0]), .use_spi,
        .reg_sel_q, .chan_sel_q, .acc_read_q, .wr_stb_q, .wr_data_q,
        .rd_stb_q, .rd_data);
    srafe_properties u_srafe_properties (.mclk, .rst_n,
        .scl(u_srafe_if.scl), .sda(u_srafe_if.sda),
        .dev_sda_oe_n(u_srafe_if.dev_sda_oe_n), .cs_n(u_srafe_if.cs_n),
        .sclk(u_srafe_if.sclk), .miso(u_srafe_if.miso));
    ////////////////////
    // Tally strobes; next write byte goes out off the edge
    always @(posedge mclk) begin
        if (wr_stb_q) last_wr <= wr_data_q;
        nwr <= nwr + int'(wr_stb_q);
        nrd <= nrd + int'(rd_valid_q);
        nrs <= nrs + int'(rd_stb_q);
    end
    always @(negedge mclk) if (wr_take_q) wr_data <= wr_data + 8'h11;
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] e, a);
        comparisons++;
        if (a !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, a);
        end
    endtask : chk
    // One access: mode, direction, refusal, target, register, length
    task automatic go(input logic s, r, nk, input logic [3:0] t, g,
                      input logic [7:0] n);
        use_spi = s;
        repeat (4) @(negedge mclk);
        {req_spi, req_read, req_tgt, req_reg, req_len} = {s, r, t, g, n};
        {nwr, nrd, nrs, wr_data, req} = {32'h0, 32'h0, 32'h0, 8'h10, 1'h1};
        @(negedge mclk);
        req = 1'h0;
        chk("busy", 8'h1, {7'h0, busy_q});
        while (done_q !== 1'h1) @(negedge mclk);
        chk("idle", 8'h0, {7'h0, busy_q});
        // Four-wire reads fetch one byte ahead of the frame's end
        chk("fetch", (r && !nk) ? n + {7'h0, s} : 8'h0, 8'(nrs));
        chk("nack", {7'h0, nk}, {7'h0, nack_q});
        chk("count", nk ? 8'h0 : n, 8'(nwr + nrd));
        if (!nk) chk("decode", {r, g, 3'h0},
                     {acc_read_q, reg_sel_q, chan_sel_q, 1'h0});
        if (!nk) chk("data", r ? {4'ha, g} : 8'h10 + 8'h11 * (n - 8'h1),
                     r ? rd_data_q : last_wr);
        $display("test done: spi %0d read %0d", s, r);
    endtask : go
    // Counts and verdict
    task print_verdict;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    ////////////////////
    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1'h1;
        go(1'h0, 1'h0, 1'h0, 4'h5, 4'h5, 8'h2);
        go(1'h0, 1'h1, 1'h0, 4'h5, 4'h9, 8'h2);
        go(1'h1, 1'h0, 1'h0, 4'h5, 4'hf, 8'h1);
        go(1'h1, 1'h1, 1'h0, 4'h5, 4'h3, 8'h3);
        go(1'h0, 1'h0, 1'h1, 4'h6, 4'h2, 8'h1);
        strap = 4'hf;
        go(1'h0, 1'h1, 1'h0, 4'hf, 4'h0, 8'h1);
        print_verdict();
    end
    // Watchdog well past the expected run length
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule : serial_register_address_front_end_tb
`default_nettype wire
